/* slf_top.sv */
module slf_top
   import slf_pkg::*;
#(
   parameter int PROG_CYCLES = slf_pkg::PROG_CYC
)
(
   input  wire logic                       CLK,
   input  wire logic                       RST,
   input  wire logic                       PORST,
   input  wire logic                       HSEL,
   input  wire logic [31:0]                HADDR,
   input  wire logic [1:0]                 HTRANS,
   input  wire logic                       HWRITE,
   input  wire logic [2:0]                 HSIZE,
   input  wire logic [31:0]                HWDATA,
   input  wire logic                       HREADY,
   output logic                            HREADYOUT,
   output logic                            HRESP,
   output logic      [31:0]                HRDATA,
   input  wire logic                       EE_WRITE_BUSY,
   input  wire logic [7:0]                 FUSE_LOW,
   input  wire logic [7:0]                 FUSE_HIGH,
   input  wire logic [2:0]                 FUSE_EXT,
   input  wire logic [7:0]                 FLASH_RDATA,
   output logic                            FLASH_RD,
   output logic      [slf_pkg::PTR_W-1:0]  FLASH_ADDR,
   output logic                            FLASH_ERASE,
   output logic                            FLASH_WRITE,
   output logic      [7:0]                 FLASH_PAGE,
   output logic      [5:0]                 LOCK_BITS,
   output logic                            SECTION_BUSY,
   output logic                            BUF_CLEAR,
   output logic                            SPM_IRQ
);
   import slf_pkg::*;

   logic             wr_pend;
   logic [7:0]       wr_off;
   logic             ahb_take;
   logic             ld_go;
   logic             wr_ctrl;
   logic             wr_store;
   logic             ctrl_ok;
   logic             arm;
   logic             arm_lock;
   logic             store_go;
   logic             lf_hit;
   logic             blocked;
   logic             prog_start;
   logic             prog_busy;
   logic             prog_done;
   logic             prog_is_wr;
   logic             st_act;
   logic             st_last;
   logic             ld_act;
   logic             irq_en;
   logic [3:0]       cmd;
   logic             store_prog_enable;
   logic             rww_busy;
   logic [5:0]       lock;
   logic [7:0]       oper;
   logic [PTR_W-1:0] ptr;
   logic [7:0]       fuse_byte;
   logic [7:0]       fuse_hold;
   logic [1:0]       ld_src;
   logic [31:0]      next_rdata;
   slf_ld_e          ld_st;

   assign HRESP        = 1'b0;
   assign LOCK_BITS    = lock;
   assign SECTION_BUSY = rww_busy;

   assign ahb_take = HSEL & HTRANS[1] & HREADY;
   assign ld_go    = ahb_take & ~HWRITE & (HADDR[7:0] == OFF_LOAD);
   assign wr_ctrl  = wr_pend & (wr_off == OFF_CTRL);
   assign wr_store = wr_pend & (wr_off == OFF_STORE);

   // control writes are dropped while eeprom or flash are busy
   assign ctrl_ok  = wr_ctrl & ~EE_WRITE_BUSY & ~prog_busy;
   assign arm      = ctrl_ok & HWDATA[B_STORE_PROG_ENABLE];
   assign arm_lock = arm & (HWDATA[4:1] == CMD_LOCK);
   assign store_go = wr_store & store_prog_enable & st_act & ~EE_WRITE_BUSY
                     & ~prog_busy;
   assign lf_hit   = ld_go & ld_act & store_prog_enable & (cmd == CMD_LOCK)
                     & ~EE_WRITE_BUSY;
   assign blocked  = rww_busy & (ptr < RWW_LIMIT);
   assign prog_start = store_go & ((cmd == CMD_ERASE) | (cmd == CMD_WRITE)
                       | (cmd == CMD_LOCK));

   slf_win #(.W(3)) u_store_win
   (
      .clk    (CLK),
      .rst    (RST),
      .start  (arm),
      .stop   (store_go | lf_hit),
      .len    (STORE_WIN),
      .active (st_act),
      .last   (st_last)
   );

   slf_win #(.W(3)) u_load_win
   (
      .clk    (CLK),
      .rst    (RST),
      .start  (arm_lock),
      .stop   (store_go | lf_hit),
      .len    (LOAD_WIN),
      .active (ld_act),
      .last   ()
   );

   // on power-on reset only, so a system reset cannot cut a write short
   slf_win #(.W(PROG_W)) u_prog_timer
   (
      .clk    (CLK),
      .rst    (PORST),
      .start  (prog_start),
      .stop   (1'b0),
      .len    (PROG_W'(PROG_CYCLES)),
      .active (prog_busy),
      .last   (prog_done)
   );

   slf_fuse_mux u_fuse_mux
   (
      .sel       (ptr[1:0]),
      .lock      (lock),
      .fuse_low  (FUSE_LOW),
      .fuse_high (FUSE_HIGH),
      .fuse_ext  (FUSE_EXT),
      .byte_out  (fuse_byte)
   );

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_pend <= 1'b0;
         wr_off  <= 8'h00;
      end
      else
      begin
         wr_pend <= ahb_take & HWRITE;
         if (ahb_take)
            wr_off <= HADDR[7:0];
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         oper <= 8'h00;
         ptr  <= '0;
      end
      else if (wr_pend && wr_off == OFF_OPER)
         oper <= HWDATA[7:0];
      else if (wr_pend && wr_off == OFF_PTR)
         ptr <= HWDATA[PTR_W-1:0];
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         irq_en <= 1'b0;
         cmd    <= CMD_FILL;
         store_prog_enable  <= 1'b0;
      end
      else if (ctrl_ok)
      begin
         irq_en <= HWDATA[B_IE];
         cmd    <= HWDATA[4:1];
         store_prog_enable  <= HWDATA[B_STORE_PROG_ENABLE];
      end
      else if (lf_hit)
      begin
         cmd   <= CMD_FILL;
         store_prog_enable <= 1'b0;
      end
      else if (store_go && !prog_start)
      begin
         cmd   <= CMD_FILL;
         store_prog_enable <= 1'b0;
      end
      else if (prog_done || (st_last && !store_go))
      begin
         cmd   <= CMD_FILL;
         store_prog_enable <= 1'b0;
      end
   end

   // busy flag and lock bits survive a system reset like the flash does
   always_ff @(posedge CLK or posedge PORST)
   begin
      if (PORST)
         rww_busy <= 1'b0;
      else if (prog_start && cmd != CMD_LOCK && ptr < RWW_LIMIT)
         rww_busy <= 1'b1;
      else if (store_go && cmd == CMD_REEN)
         rww_busy <= 1'b0;
   end

   always_ff @(posedge CLK or posedge PORST)
   begin
      if (PORST)
         lock <= LOCK_RST;
      else if (store_go && cmd == CMD_LOCK)
         lock <= lock & oper[5:0];
   end

   always_ff @(posedge CLK or posedge PORST)
   begin
      if (PORST)
         prog_is_wr <= 1'b0;
      else if (prog_start)
         prog_is_wr <= (cmd == CMD_WRITE);
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         FLASH_ERASE <= 1'b0;
         FLASH_WRITE <= 1'b0;
         FLASH_PAGE  <= 8'h00;
      end
      else
      begin
         FLASH_ERASE <= prog_start & (cmd == CMD_ERASE);
         FLASH_WRITE <= prog_start & (cmd == CMD_WRITE);
         if (prog_start)
            FLASH_PAGE <= ptr[14:7];
      end
   end

   // held high through system reset so the buffer is wiped on every system reset
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         BUF_CLEAR <= 1'b1;
      else
         BUF_CLEAR <= (prog_done & prog_is_wr)
                      | (store_go & (cmd == CMD_REEN));
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         SPM_IRQ <= 1'b0;
      else
         SPM_IRQ <= irq_en & ~store_prog_enable;
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         ld_st <= LD_IDLE;
      else
         case (ld_st)
            LD_IDLE:
               if (ld_go)
                  ld_st <= LD_WAIT;
            LD_WAIT:
               ld_st <= LD_DATA;
            LD_DATA:
               ld_st <= LD_IDLE;
            default:
               ld_st <= LD_IDLE;
         endcase
   end

   // lock programming never marks the section busy, so reads go on
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         ld_src     <= SRC_FLASH;
         fuse_hold  <= 8'h00;
         FLASH_RD   <= 1'b0;
         FLASH_ADDR <= '0;
      end
      else
      begin
         FLASH_RD <= ld_go & ~lf_hit & ~blocked;
         if (ld_go)
         begin
            FLASH_ADDR <= ptr;
            fuse_hold  <= fuse_byte;
            if (lf_hit)
               ld_src <= SRC_FUSE;
            else if (blocked)
               ld_src <= SRC_BLOCK;
            else
               ld_src <= SRC_FLASH;
         end
      end
   end

   always_comb
   begin
      next_rdata = 32'h0;
      if (HADDR[7:0] == OFF_CTRL)
         next_rdata = {24'h0, irq_en, rww_busy, 1'b0, cmd, store_prog_enable};
      else if (HADDR[7:0] == OFF_OPER)
         next_rdata = {24'h0, oper};
      else if (HADDR[7:0] == OFF_PTR)
         next_rdata = {16'h0, ptr};
      else if (HADDR[7:0] == OFF_STAT)
         next_rdata = {18'h0, lock, 6'h0, EE_WRITE_BUSY, prog_busy};
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         HREADYOUT <= 1'b1;
         HRDATA    <= 32'h0;
      end
      else if (ld_go)
         HREADYOUT <= 1'b0;
      else if (ld_st == LD_DATA)
      begin
         HREADYOUT <= 1'b1;
         if (ld_src == SRC_FUSE)
            HRDATA <= {24'h0, fuse_hold};
         else if (ld_src == SRC_BLOCK)
            HRDATA <= 32'h0000_00ff;
         else
            HRDATA <= {24'h0, FLASH_RDATA};
      end
      else if (ahb_take && !HWRITE)
         HRDATA <= next_rdata;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST || PORST);

   a_rww_read_block: assert property
      (ld_go && blocked && !lf_hit
       |=> !FLASH_RD ##2 HRDATA == 32'h0000_00ff)
      else $error("load reached a busy section");
   a_busy_flag_held: assert property
      (rww_busy && !(store_go && cmd == CMD_REEN) |=> rww_busy)
      else $error("section busy dropped without re-enable");
   a_lock_bits_prog: assert property
      (store_go && cmd == CMD_LOCK
       |=> LOCK_BITS == ($past(LOCK_BITS) & $past(oper[5:0])))
      else $error("lock bits not programmed from operand");
   a_lock_read_open: assert property
      (store_go && cmd == CMD_LOCK |=> rww_busy == $past(rww_busy))
      else $error("lock write blocked flash reads");
   a_ee_store_refuse: assert property
      (wr_store && EE_WRITE_BUSY
       |=> !FLASH_ERASE && !FLASH_WRITE && LOCK_BITS == $past(LOCK_BITS))
      else $error("store taken during eeprom write");
   a_ee_fuse_refuse: assert property
      (ld_go && EE_WRITE_BUSY |=> ld_src != SRC_FUSE)
      else $error("fuse readback during eeprom write");
   a_window_expiry: assert property
      (arm && !arm_lock ##1 (!wr_pend && !ld_go && !prog_busy)[*4]
       |=> !store_prog_enable)
      else $error("store enable survived its window");
   a_plain_load: assert property
      (ld_go && !store_prog_enable && !blocked |=> FLASH_RD)
      else $error("plain load did not read flash");
   a_fuse_low_read: assert property
      (lf_hit && ptr[1:0] == SEL_FLB |-> ##3 HRDATA[7:0] == $past(FUSE_LOW, 3))
      else $error("wrong fuse low byte");
   a_fuse_high_read: assert property
      (lf_hit && ptr[1:0] == 2'h3 |-> ##3 HRDATA[7:0] == $past(FUSE_HIGH, 3))
      else $error("wrong fuse high byte");
   a_reenable_clear: assert property
      (store_go && cmd == CMD_REEN |=> !rww_busy && BUF_CLEAR)
      else $error("re-enable left busy flag or buffer");
   a_irq_level: assert property
      (irq_en && !store_prog_enable ##1 irq_en && !store_prog_enable |-> SPM_IRQ)
      else $error("interrupt not held while store enable clear");
   a_window_start: assert property
      (arm |=> st_act && store_prog_enable ##3 (st_act || !store_prog_enable || prog_busy))
      else $error("store window not opened on control write");
endmodule

/* slf_pkg.sv */
package slf_pkg;
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_OPER   = 8'h04;
   localparam logic [7:0]  OFF_PTR    = 8'h08;
   localparam logic [7:0]  OFF_STORE  = 8'h0c;
   localparam logic [7:0]  OFF_LOAD   = 8'h10;
   localparam logic [7:0]  OFF_STAT   = 8'h14;
   localparam int          B_IE       = 7;
   localparam int          B_BUSY     = 6;
   localparam int          B_STORE_PROG_ENABLE    = 0;
   localparam logic [3:0]  CMD_FILL   = 4'h0;
   localparam logic [3:0]  CMD_ERASE  = 4'h1;
   localparam logic [3:0]  CMD_WRITE  = 4'h2;
   localparam logic [3:0]  CMD_LOCK   = 4'h4;
   localparam logic [3:0]  CMD_REEN   = 4'h8;
   localparam logic [2:0]  STORE_WIN  = 3'h4;
   localparam logic [2:0]  LOAD_WIN   = 3'h3;
   localparam int          PTR_W      = 16;
   localparam logic [1:0]  SEL_FLB    = 2'h0;
   localparam logic [1:0]  SEL_LOCK   = 2'h1;
   localparam logic [1:0]  SEL_EFB    = 2'h2;
   localparam logic [15:0] RWW_LIMIT  = 16'h7000;
   localparam logic [5:0]  LOCK_RST   = 6'h3f;
   localparam int          CLK_MHZ    = 125;
   localparam int          PROG_US    = 3700;
   localparam int          PROG_CYC   = PROG_US * CLK_MHZ;
   localparam int          PROG_W     = 20;
   localparam logic [1:0]  SRC_FLASH  = 2'h0;
   localparam logic [1:0]  SRC_FUSE   = 2'h1;
   localparam logic [1:0]  SRC_BLOCK  = 2'h2;
   typedef enum logic [1:0]
   {
      LD_IDLE = 2'h0,
      LD_WAIT = 2'h1,
      LD_DATA = 2'h3
   } slf_ld_e;
endpackage

/* slf_win.sv */
module slf_win
#(
   parameter int W = 3
)
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic         stop,
   input  wire logic [W-1:0] len,
   output logic              active,
   output logic              last
);
   logic [W-1:0] cnt;

   // restart wins over stop so a re-arm is never lost
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt <= '0;
      else if (start)
         cnt <= len;
      else if (stop)
         cnt <= '0;
      else if (cnt != '0)
         cnt <= cnt - 1'b1;
   end

   assign active = (cnt != '0);
   assign last   = (cnt == W'(1));
endmodule

/* slf_fuse_mux.sv */
module slf_fuse_mux
(
   input  wire logic [1:0] sel,
   input  wire logic [5:0] lock,
   input  wire logic [7:0] fuse_low,
   input  wire logic [7:0] fuse_high,
   input  wire logic [2:0] fuse_ext,
   output logic      [7:0] byte_out
);
   import slf_pkg::*;

   // stored active low, so programmed bits come out as zero
   always_comb
   begin
      if (sel == SEL_FLB)
         byte_out = fuse_low;
      else if (sel == SEL_LOCK)
         byte_out = {2'h3, lock};
      else if (sel == SEL_EFB)
         byte_out = {5'h1f, fuse_ext};
      else
         byte_out = fuse_high;
   end
endmodule

/* slf_flash_model.sv */
module slf_flash_model
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        rd,
   input  wire logic [15:0] addr,
   output logic      [7:0]  rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // byte answers the cycle after the strobe; otherwise the bus wanders
   // so that a sample one cycle late can never happen to look right
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (rd)
         rdata <= addr[7:0] ^ addr[15:8] ^ 8'h5a;
      else
         rdata <= ~rdata;
   end
endmodule

/* slf_top_bench.sv */
`define CHK(g, e) chk((g) !== (e))

module slf_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import slf_pkg::*;
   localparam int PC = 20;
   logic        clk    = 1'b0;
   logic        rst    = 1'b1;
   logic        porst  = 1'b1;
   logic        hsel   = 1'b0;
   logic [31:0] haddr  = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        ee     = 1'b0;
   logic [7:0]  fuse_lo = 8'h00;
   logic [7:0]  fuse_hi = 8'h00;
   logic [2:0]  fuse_ex = 3'h0;
   logic [31:0] seed   = 32'h2d0e;
   logic [31:0] d;
   logic [5:0]  m_lock = 6'h3f;
   logic [7:0]  op;
   logic [15:0] p;
   wire         hreadyout;
   wire         hresp;
   wire  [31:0] hrdata;
   wire  [7:0]  flash_rdata;
   wire         flash_rd;
   wire  [15:0] flash_addr;
   wire  [5:0]  lock_bits;
   wire         section_busy;
   wire         buf_clear;
   wire         spm_irq;
   int          n_errors = 0;
   int          n_checks = 0;
   int          n_bufclr = 0;
   int          cyc      = 0;
   int          bc;
   int          i;

   always #4 clk = ~clk;

   slf_top #(.PROG_CYCLES(PC)) u_slf_top
   (
      .CLK          (clk),
      .RST          (rst),
      .PORST        (porst),
      .HSEL         (hsel),
      .HADDR        (haddr),
      .HTRANS       (htrans),
      .HWRITE       (hwrite),
      .HSIZE        (3'h2),
      .HWDATA       (hwdata),
      .HREADY       (hreadyout),
      .HREADYOUT    (hreadyout),
      .HRESP        (hresp),
      .HRDATA       (hrdata),
      .EE_WRITE_BUSY(ee),
      .FUSE_LOW     (fuse_lo),
      .FUSE_HIGH    (fuse_hi),
      .FUSE_EXT     (fuse_ex),
      .FLASH_RDATA  (flash_rdata),
      .FLASH_RD     (flash_rd),
      .FLASH_ADDR   (flash_addr),
      .FLASH_ERASE  (),
      .FLASH_WRITE  (),
      .FLASH_PAGE   (),
      .LOCK_BITS    (lock_bits),
      .SECTION_BUSY (section_busy),
      .BUF_CLEAR    (buf_clear),
      .SPM_IRQ      (spm_irq)
   );

   slf_flash_model u_slf_flash_model
   (
      .clk  (clk),
      .rst  (rst),
      .rd   (flash_rd),
      .addr (flash_addr),
      .rdata(flash_rdata)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [7:0] fl(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction

   // expected readback byte, unused upper bits read as unprogrammed
   function automatic logic [7:0] rb(input logic [1:0] s);
      case (s)
         2'h0: return fuse_lo;
         2'h1: return {2'b11, m_lock};
         2'h2: return {5'h1f, fuse_ex};
         default: return fuse_hi;
      endcase
   endfunction

   task automatic chk(input logic bad);
      n_checks++;
      if (bad)
      begin
         n_errors++;
         $display("[FAIL] %0t compare mismatch", $time);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one single transfer; address held until ready, data until ready
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] r);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wait_idle();
      xfer(OFF_STAT, 1'b0, 32'h0, d);
      while (d[0] !== 1'b0)
         xfer(OFF_STAT, 1'b0, 32'h0, d);
   endtask

   always @(posedge clk)
   begin
      if (buf_clear === 1'b1 && rst === 1'b0)
         n_bufclr++;
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("[FAIL] %0t run took too long", $time);
         end_sim();
      end
   end

   initial
   begin
      repeat (16) @(posedge clk);
      `CHK(buf_clear, 1'b1);
      `CHK(lock_bits, 6'h3f);
      `CHK(hreadyout, 1'b1);
      seed = lfsr(seed);
      fuse_lo <= seed[7:0];
      fuse_hi <= seed[15:8];
      fuse_ex <= seed[18:16];
      rst <= 1'b0;
      porst <= 1'b0;
      hsel <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         xfer(OFF_PTR, 1'b1, seed, d);
         xfer(OFF_LOAD, 1'b0, 32'h0, d);
         `CHK(d[7:0], fl(seed[15:0]));
      end
      xfer(8'h3c, 1'b1, 32'hffff_ffff, d);
      xfer(8'h3c, 1'b0, 32'h0, d);
      `CHK(d, 32'h0);
      `CHK(hresp, 1'b0);
      // every readback selector, load right after the arming write
      for (i = 0; i < 4; i++)
      begin
         xfer(OFF_PTR, 1'b1, 32'(i), d);
         xfer(OFF_CTRL, 1'b1, 32'h09, d);
         xfer(OFF_LOAD, 1'b0, 32'h0, d);
         `CHK(d[7:0], rb(i[1:0]));
         xfer(OFF_CTRL, 1'b0, 32'h0, d);
         `CHK(d[3:0], 4'h0);
      end
      xfer(OFF_CTRL, 1'b1, 32'h09, d);
      repeat (4) @(posedge clk);
      xfer(OFF_LOAD, 1'b0, 32'h0, d);
      `CHK(d[7:0], fl(16'h0003));
      // zero operand with a late store would program every lock bit
      xfer(OFF_OPER, 1'b1, 32'h0, d);
      xfer(OFF_CTRL, 1'b1, 32'h09, d);
      repeat (6) @(posedge clk);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      `CHK(lock_bits, m_lock);
      seed = lfsr(seed);
      op = {2'b11, seed[5:0]};
      p = {4'h0, seed[27:16]};
      xfer(OFF_OPER, 1'b1, {24'h0, op}, d);
      xfer(OFF_PTR, 1'b1, {16'h0, p}, d);
      xfer(OFF_CTRL, 1'b1, 32'h09, d);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      m_lock = m_lock & op[5:0];
      xfer(OFF_LOAD, 1'b0, 32'h0, d);
      `CHK(d[7:0], fl(p));
      `CHK(section_busy, 1'b0);
      wait_idle();
      `CHK(lock_bits, m_lock);
      xfer(OFF_PTR, 1'b1, 32'h1, d);
      xfer(OFF_CTRL, 1'b1, 32'h09, d);
      ee <= 1'b1;
      xfer(OFF_LOAD, 1'b0, 32'h0, d);
      `CHK(d[7:0], fl(16'h0001));
      xfer(OFF_CTRL, 1'b1, 32'h09, d);
      xfer(OFF_CTRL, 1'b0, 32'h0, d);
      `CHK(d[0], 1'b0);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      `CHK(lock_bits, m_lock);
      ee <= 1'b0;
      // software polls eeprom busy before touching the control register
      xfer(OFF_STAT, 1'b0, 32'h0, d);
      `CHK(d[1], 1'b0);
      // erase inside the concurrent-read section, reset in mid-program
      xfer(OFF_PTR, 1'b1, 32'h0100, d);
      xfer(OFF_CTRL, 1'b1, 32'h03, d);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      repeat (2) @(posedge clk);
      `CHK(section_busy, 1'b1);
      xfer(OFF_LOAD, 1'b0, 32'h0, d);
      `CHK(d[7:0], 8'hff);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK(section_busy, 1'b1);
      wait_idle();
      xfer(OFF_CTRL, 1'b0, 32'h0, d);
      `CHK(d[6], 1'b1);
      bc = n_bufclr;
      xfer(OFF_CTRL, 1'b1, 32'h11, d);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      repeat (2) @(posedge clk);
      `CHK(section_busy, 1'b0);
      `CHK(n_bufclr - bc, 1);
      // system reset cleared the pointer, so load it again
      xfer(OFF_PTR, 1'b1, 32'h0100, d);
      xfer(OFF_LOAD, 1'b0, 32'h0, d);
      `CHK(d[7:0], fl(16'h0100));
      bc = n_bufclr;
      xfer(OFF_PTR, 1'b1, 32'h7100, d);
      xfer(OFF_CTRL, 1'b1, 32'h05, d);
      xfer(OFF_STORE, 1'b1, 32'h0, d);
      repeat (2) @(posedge clk);
      `CHK(section_busy, 1'b0);
      wait_idle();
      repeat (3) @(posedge clk);
      `CHK(n_bufclr - bc, 1);
      xfer(OFF_CTRL, 1'b1, 32'h80, d);
      repeat (2) @(posedge clk);
      `CHK(spm_irq, 1'b1);
      xfer(OFF_CTRL, 1'b1, 32'h0, d);
      repeat (2) @(posedge clk);
      `CHK(spm_irq, 1'b0);
      end_sim();
   end
endmodule
